/* File: common/ssc_consts.svh */
// offsets, field positions, reset values and timing counts of the sideband control block
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// ****************************************
// i2c device address
// ****************************************
`define SSC_DEV_ADDR        7'h0C

// ****************************************
// register offsets
// ****************************************
`define SSC_OFS_ALT_FREQ    8'h04
`define SSC_OFS_LINK_DET    8'h0C
`define SSC_OFS_GPIO0       8'h0D
`define SSC_OFS_GPIO21      8'h0E
`define SSC_OFS_GPIO3_OUT4  8'h0F
`define SSC_OFS_OUT65       8'h10
`define SSC_OFS_OUT7        8'h11
`define SSC_OFS_COLOUR      8'h12
`define SSC_OFS_EDGE_AUDIO  8'h13
`define SSC_OFS_PATTERN     8'h14
`define SSC_OFS_FREQUENCY_SELECT_PIN        8'h35
`define SSC_OFS_INT_CTRL    8'hC6
`define SSC_OFS_INT_STAT    8'hC7

// ****************************************
// field positions
// ****************************************
`define SSC_ALT_OVR_EN      1
`define SSC_ALT_OVR_VAL     0
`define SSC_FREQUENCY_SELECT_PIN_OVR_EN     7
`define SSC_FREQUENCY_SELECT_PIN_OVR_VAL    6
`define SSC_MODE18_BIT      2
`define SSC_EDGE_BIT        0
`define SSC_AUDIO_AV_BIT    1
`define SSC_PAT_EN_BIT      0
`define SSC_INT_GLOBAL_BIT  0
`define SSC_INT_REMOTE_BIT  5
`define SSC_NIB_EN          0
`define SSC_NIB_IN          1
`define SSC_NIB_OUT         2
`define SSC_NIB_VAL         3

// ****************************************
// reset values
// ****************************************
`define SSC_RST_ZERO        8'h00
`define SSC_RST_EDGE_AUDIO  8'h01

// ****************************************
// timing counts
// ****************************************
`define SSC_PCLK_LOSS_CYC   8'h40

`endif

/* File: common/ssc_pkg.sv */
// types shared by the sideband control block
`default_nettype none
package ssc_pkg;

   // i2c slave states, one-hot
   typedef enum logic [6:0] {
      SSC_ST_IDLE  = 7'h01,
      SSC_ST_ADDR  = 7'h02,
      SSC_ST_AACK  = 7'h04,
      SSC_ST_WBYTE = 7'h08,
      SSC_ST_WACK  = 7'h10,
      SSC_ST_RBYTE = 7'h20,
      SSC_ST_RACK  = 7'h40
   } ssc_i2c_state_t;

   typedef struct packed {
      logic high_frequency_mode;
      logic intermediate_frequency_mode;
      logic low_frequency_mode;
   } ssc_freq_mode_t;

   typedef struct packed {
      logic clk;
      logic ws;
      logic da;
   } ssc_i2s_t;

endpackage
`default_nettype wire

/* File: hdl/ssc_top.sv */
// sideband control logic of the video serializer: i2c registers, modes, interrupts, gpio
`timescale 1ns/1ns
`include "ssc_consts.svh"
`default_nettype none

module ssc_top (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   // i2c control bus, open drain data
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   output logic                       sda_o,
   output logic                       sda_oe_o,
   // mode pins and power
   input  wire logic                  frequency_select_pin_i,
   input  wire logic                  mode_sel_alt_freq_i,
   input  wire logic                  pdb_n_i,
   output ssc_pkg::ssc_freq_mode_t    freq_mode_o,
   // link status
   input  wire logic [5:0]            link_fault_i,
   input  wire logic                  remote_lock_i,
   input  wire logic                  downstream_interrupt_in_n_i,
   // interrupt outputs
   output logic                       remote_interrupt_mirror_n_o,
   output logic                       local_interrupt_n_o,
   // parallel video
   input  wire logic                  pclk_pin_i,
   input  wire logic [23:0]           pix_data_i,
   output logic [23:0]                pix_data_o,
   output logic                       pix_valid_o,
   output logic                       pclk_edge_select_o,
   output logic                       mode18_o,
   // gpio on R[1:0], G[1:0]
   input  wire logic [3:0]            gpio_i,
   output logic [3:0]                 gpio_o,
   output logic [3:0]                 gpio_oe_o,
   input  wire logic [3:0]            bc_gpio_i,
   output logic [3:0]                 fwd_gpio_o,
   // register driven outputs 7..4
   input  wire logic [3:0]            gpo_i,
   output logic [3:0]                 gpo_o,
   output logic [3:0]                 gpo_oe_o,
   // audio
   input  wire ssc_pkg::ssc_i2s_t     i2s_i,
   output ssc_pkg::ssc_i2s_t          i2s_o,
   output logic                       audio_active_video_o
);

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] alt_freq_reg, gpio0_reg, gpio21_reg, gpio3_out4_reg, out65_reg, out7_reg;
   logic [7:0] colour_reg, edge_audio_reg, pattern_reg, frequency_select_pin_reg, int_ctrl_reg;
   logic [7:0] link_det_reg;
   logic       int_pend_reg;
   logic [7:0] rd_data;
   logic       wr_stb;
   logic       isr_rd_stb;
   logic [7:0] ptr_reg;
   logic [7:0] shift_reg;
   logic       mode18;

   assign mode18 = colour_reg[`SSC_MODE18_BIT];

   // ****************************************
   // i2c slave
   // ****************************************
   ssc_pkg::ssc_i2c_state_t state_reg;
   logic       scl_q, sda_q, scl_prev, sda_prev;
   logic [3:0] bit_cnt_reg;
   logic       rw_reg, got_ptr_reg, nack_reg;
   logic       start_det, stop_det, scl_rise, scl_fall;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_q    <= scl_i;
         sda_q    <= sda_i;
         scl_prev <= scl_q;
         sda_prev <= sda_q;
      end
   end

   assign start_det = scl_q & scl_prev & sda_prev & ~sda_q;
   assign stop_det  = scl_q & scl_prev & ~sda_prev & sda_q;
   assign scl_rise  = scl_q & ~scl_prev;
   assign scl_fall  = ~scl_q & scl_prev;

   always_comb begin
      unique case (ptr_reg)
         `SSC_OFS_ALT_FREQ:   rd_data = alt_freq_reg;
         `SSC_OFS_LINK_DET:   rd_data = link_det_reg;
         `SSC_OFS_GPIO0:      rd_data = gpio0_reg;
         `SSC_OFS_GPIO21:     rd_data = gpio21_reg;
         `SSC_OFS_GPIO3_OUT4: rd_data = gpio3_out4_reg;
         `SSC_OFS_OUT65:      rd_data = out65_reg;
         `SSC_OFS_OUT7:       rd_data = out7_reg;
         `SSC_OFS_COLOUR:     rd_data = colour_reg;
         `SSC_OFS_EDGE_AUDIO: rd_data = edge_audio_reg;
         `SSC_OFS_PATTERN:    rd_data = pattern_reg;
         `SSC_OFS_FREQUENCY_SELECT_PIN:       rd_data = frequency_select_pin_reg;
         `SSC_OFS_INT_CTRL:   rd_data = int_ctrl_reg;
         `SSC_OFS_INT_STAT:   rd_data = {2'h0, int_pend_reg, 5'h00};
         default:             rd_data = 8'h00;
      endcase
   end

   // write strobe fires on the scl fall that ends a data byte after the pointer, status-read strobe on the fall that ends the acknowledge before a read byte
   assign wr_stb     = (state_reg == ssc_pkg::SSC_ST_WBYTE) & scl_fall
                       & (bit_cnt_reg == 4'h8) & got_ptr_reg;
   assign isr_rd_stb = scl_fall & (ptr_reg == `SSC_OFS_INT_STAT) & ~rw_reg ? 1'b0 :
                       scl_fall & (ptr_reg == `SSC_OFS_INT_STAT)
                       & (((state_reg == ssc_pkg::SSC_ST_AACK) & rw_reg)
                       | ((state_reg == ssc_pkg::SSC_ST_RACK) & ~nack_reg));

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg   <= ssc_pkg::SSC_ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         ptr_reg     <= 8'h00;
         rw_reg      <= 1'b0;
         got_ptr_reg <= 1'b0;
         nack_reg    <= 1'b0;
         sda_oe_o    <= 1'b0;
      end else if (start_det) begin
         state_reg   <= ssc_pkg::SSC_ST_ADDR;
         bit_cnt_reg <= 4'h0;
         got_ptr_reg <= 1'b0;
         sda_oe_o    <= 1'b0;
      end else if (stop_det) begin
         state_reg <= ssc_pkg::SSC_ST_IDLE;
         sda_oe_o  <= 1'b0;
      end else begin
         unique case (state_reg)
            ssc_pkg::SSC_ST_IDLE: begin
               sda_oe_o <= 1'b0;
            end
            ssc_pkg::SSC_ST_ADDR, ssc_pkg::SSC_ST_WBYTE: begin
               if (scl_rise && bit_cnt_reg != 4'h8) begin
                  shift_reg   <= {shift_reg[6:0], sda_q};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                  bit_cnt_reg <= 4'h0;
                  if (state_reg == ssc_pkg::SSC_ST_ADDR) begin
                     if (shift_reg[7:1] == `SSC_DEV_ADDR) begin
                        rw_reg    <= shift_reg[0];
                        sda_oe_o  <= 1'b1;
                        state_reg <= ssc_pkg::SSC_ST_AACK;
                     end else begin
                        state_reg <= ssc_pkg::SSC_ST_IDLE;
                     end
                  end else begin
                     if (!got_ptr_reg) begin
                        ptr_reg     <= shift_reg;
                        got_ptr_reg <= 1'b1;
                     end else begin
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                     sda_oe_o  <= 1'b1;
                     state_reg <= ssc_pkg::SSC_ST_WACK;
                  end
               end
            end
            ssc_pkg::SSC_ST_AACK: begin
               if (scl_fall) begin
                  if (rw_reg) begin
                     shift_reg <= rd_data;
                     ptr_reg   <= ptr_reg + 8'h01;
                     sda_oe_o  <= ~rd_data[7];
                     state_reg <= ssc_pkg::SSC_ST_RBYTE;
                  end else begin
                     sda_oe_o  <= 1'b0;
                     state_reg <= ssc_pkg::SSC_ST_WBYTE;
                  end
               end
            end
            ssc_pkg::SSC_ST_WACK: begin
               if (scl_fall) begin
                  sda_oe_o  <= 1'b0;
                  state_reg <= ssc_pkg::SSC_ST_WBYTE;
               end
            end
            ssc_pkg::SSC_ST_RBYTE: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == 4'h7) begin
                     bit_cnt_reg <= 4'h0;
                     sda_oe_o    <= 1'b0;
                     state_reg   <= ssc_pkg::SSC_ST_RACK;
                  end else begin
                     shift_reg   <= {shift_reg[6:0], 1'b0};
                     sda_oe_o    <= ~shift_reg[6];
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            ssc_pkg::SSC_ST_RACK: begin
               if (scl_rise) begin
                  nack_reg <= sda_q;
               end else if (scl_fall) begin
                  if (nack_reg) begin
                     state_reg <= ssc_pkg::SSC_ST_IDLE;
                  end else begin
                     shift_reg <= rd_data;
                     ptr_reg   <= ptr_reg + 8'h01;
                     sda_oe_o  <= ~rd_data[7];
                     state_reg <= ssc_pkg::SSC_ST_RBYTE;
                  end
               end
            end
         endcase
      end
   end

   // open drain: only ever pull low
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // ****************************************
   // register file writes
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         alt_freq_reg   <= `SSC_RST_ZERO;
         gpio0_reg      <= `SSC_RST_ZERO;
         gpio21_reg     <= `SSC_RST_ZERO;
         gpio3_out4_reg <= `SSC_RST_ZERO;
         out65_reg      <= `SSC_RST_ZERO;
         out7_reg       <= `SSC_RST_ZERO;
         colour_reg     <= `SSC_RST_ZERO;
         edge_audio_reg <= `SSC_RST_EDGE_AUDIO;
         pattern_reg    <= `SSC_RST_ZERO;
         frequency_select_pin_reg       <= `SSC_RST_ZERO;
         int_ctrl_reg   <= `SSC_RST_ZERO;
      end else if (wr_stb) begin
         // the pointer only advances at this same edge, so it still names the target
         unique case (ptr_reg)
            `SSC_OFS_ALT_FREQ:   alt_freq_reg   <= shift_reg;
            `SSC_OFS_GPIO0:      gpio0_reg      <= shift_reg;
            `SSC_OFS_GPIO21:     gpio21_reg     <= shift_reg;
            `SSC_OFS_GPIO3_OUT4: gpio3_out4_reg <= shift_reg;
            `SSC_OFS_OUT65:      out65_reg      <= shift_reg;
            `SSC_OFS_OUT7:       out7_reg       <= shift_reg;
            `SSC_OFS_COLOUR:     colour_reg     <= shift_reg;
            `SSC_OFS_EDGE_AUDIO: edge_audio_reg <= shift_reg;
            `SSC_OFS_PATTERN:    pattern_reg    <= shift_reg;
            `SSC_OFS_FREQUENCY_SELECT_PIN:       frequency_select_pin_reg       <= shift_reg;
            `SSC_OFS_INT_CTRL:   int_ctrl_reg   <= shift_reg;
            default:             ;
         endcase
      end
   end

   // ****************************************
   // link detect and mode decode
   // ****************************************
   logic frequency_select_pin_s1, frequency_select_pin_s2, alt_s1, alt_s2, frequency_select_pin_eff, alt_eff;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         frequency_select_pin_s1 <= 1'b0;
         frequency_select_pin_s2 <= 1'b0;
         alt_s1  <= 1'b0;
         alt_s2  <= 1'b0;
      end else begin
         frequency_select_pin_s1 <= frequency_select_pin_i;
         frequency_select_pin_s2 <= frequency_select_pin_s1;
         alt_s1  <= mode_sel_alt_freq_i;
         alt_s2  <= alt_s1;
      end
   end

   assign frequency_select_pin_eff = frequency_select_pin_reg[`SSC_FREQUENCY_SELECT_PIN_OVR_EN] ? frequency_select_pin_reg[`SSC_FREQUENCY_SELECT_PIN_OVR_VAL] : frequency_select_pin_s2;
   assign alt_eff  = alt_freq_reg[`SSC_ALT_OVR_EN] ? alt_freq_reg[`SSC_ALT_OVR_VAL] : alt_s2;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         freq_mode_o  <= '0;
         link_det_reg <= 8'h00;
      end else begin
         freq_mode_o.high_frequency_mode         <= ~alt_eff;
         freq_mode_o.intermediate_frequency_mode <= frequency_select_pin_eff & alt_eff;
         freq_mode_o.low_frequency_mode          <= ~frequency_select_pin_eff & alt_eff;
         link_det_reg <= {7'h00, remote_lock_i & ~|link_fault_i};
      end
   end

   // ****************************************
   // remote interrupt
   // ****************************************
   logic rint_s1, rint_s2, rint_prev, rint_fall;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rint_s1   <= 1'b1;
         rint_s2   <= 1'b1;
         rint_prev <= 1'b1;
      end else begin
         rint_s1   <= downstream_interrupt_in_n_i;
         rint_s2   <= rint_s1;
         rint_prev <= rint_s2;
      end
   end

   assign rint_fall = rint_prev & ~rint_s2;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         int_pend_reg                <= 1'b0;
         remote_interrupt_mirror_n_o <= 1'b0;
         local_interrupt_n_o         <= 1'b1;
      end else begin
         // a new falling edge beats a status read in the same cycle
         if (rint_fall && int_ctrl_reg[`SSC_INT_REMOTE_BIT]
             && int_ctrl_reg[`SSC_INT_GLOBAL_BIT]) begin
            int_pend_reg <= 1'b1;
         end else if (isr_rd_stb) begin
            int_pend_reg <= 1'b0;
         end
         remote_interrupt_mirror_n_o <= remote_lock_i & rint_s2;
         local_interrupt_n_o <= ~(int_pend_reg & int_ctrl_reg[`SSC_INT_REMOTE_BIT]);
      end
   end

   // ****************************************
   // pixel capture and pattern generator
   // ****************************************
   logic       pclk_q, pclk_prev, cap_edge, pclk_lost, osc_tick;
   logic [7:0] loss_cnt_reg, pat_cnt_reg;
   logic [3:0] osc_cnt_reg;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pclk_q    <= 1'b0;
         pclk_prev <= 1'b0;
      end else begin
         pclk_q    <= pclk_pin_i;
         pclk_prev <= pclk_q;
      end
   end

   assign cap_edge = edge_audio_reg[`SSC_EDGE_BIT] ? (pclk_q & ~pclk_prev)
                                                   : (~pclk_q & pclk_prev);
   assign pclk_lost = (loss_cnt_reg == `SSC_PCLK_LOSS_CYC);
   assign osc_tick  = (osc_cnt_reg == pattern_reg[7:4]);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         loss_cnt_reg <= 8'h00;
         osc_cnt_reg  <= 4'h0;
         pat_cnt_reg  <= 8'h00;
      end else begin
         if (pclk_q != pclk_prev) begin
            loss_cnt_reg <= 8'h00;
         end else if (!pclk_lost) begin
            loss_cnt_reg <= loss_cnt_reg + 8'h01;
         end
         osc_cnt_reg <= osc_tick ? 4'h0 : osc_cnt_reg + 4'h1;
         if (pclk_lost ? osc_tick : cap_edge) begin
            pat_cnt_reg <= pat_cnt_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pix_data_o  <= 24'h000000;
         pix_valid_o <= 1'b0;
      end else begin
         if (pattern_reg[`SSC_PAT_EN_BIT] && pdb_n_i) begin
            pix_valid_o <= pclk_lost ? osc_tick : cap_edge;
            pix_data_o  <= {8{pat_cnt_reg[7:5]}};
         end else begin
            pix_valid_o <= cap_edge & pdb_n_i;
            if (cap_edge) begin
               // lines given over to gpio carry zero colour
               pix_data_o <= mode18 ? {pix_data_i[23:18], 2'h0, pix_data_i[15:10], 2'h0,
                                       pix_data_i[7:0]} : pix_data_i;
            end
         end
      end
   end

   // ****************************************
   // gpio and register driven outputs
   // ****************************************
   logic [7:0][3:0] nib;
   logic [3:0]      line_in;

   assign nib = {out7_reg[3:0], out65_reg[7:4], out65_reg[3:0], gpio3_out4_reg[7:4],
                 gpio3_out4_reg[3:0], gpio21_reg[7:4], gpio21_reg[3:0], gpio0_reg[3:0]};

   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_line
         assign line_in[k] = nib[k][`SSC_NIB_EN] & nib[k][`SSC_NIB_IN];
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               gpio_o[k]     <= 1'b0;
               gpio_oe_o[k]  <= 1'b0;
               gpo_o[k]      <= 1'b0;
               gpo_oe_o[k]   <= 1'b0;
               fwd_gpio_o[k] <= 1'b0;
            end else begin
               gpio_oe_o[k] <= mode18 & nib[k][`SSC_NIB_EN] & nib[k][`SSC_NIB_OUT];
               gpio_o[k]    <= bc_gpio_i[k];
               gpo_o[k]     <= nib[k+4][`SSC_NIB_VAL];
               if (k < 2) begin
                  gpo_oe_o[k]   <= nib[k+4][`SSC_NIB_EN] & ~(mode18 & nib[k+4][`SSC_NIB_IN]);
                  fwd_gpio_o[k] <= (mode18 & nib[k+4][`SSC_NIB_EN] & nib[k+4][`SSC_NIB_IN])
                                   ? gpo_i[k]
                                   : (mode18 & line_in[k] & gpio_i[k]);
               end else begin
                  gpo_oe_o[k]   <= nib[k+4][`SSC_NIB_EN];
                  fwd_gpio_o[k] <= mode18 & line_in[k] & gpio_i[k];
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // colour mode, edge select and audio
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode18_o             <= 1'b0;
         pclk_edge_select_o   <= 1'b1;
         i2s_o                <= '0;
         audio_active_video_o <= 1'b0;
      end else begin
         mode18_o             <= mode18;
         pclk_edge_select_o   <= edge_audio_reg[`SSC_EDGE_BIT];
         i2s_o                <= mode18 ? '0 : i2s_i;
         audio_active_video_o <= edge_audio_reg[`SSC_AUDIO_AV_BIT];
      end
   end

endmodule

`default_nettype wire

/* File: dv/ssc_chk.sv */
// assertion checker of the sideband control block
`timescale 1ns/1ns
`default_nettype none
module ssc_chk (
   // watched ports
   input wire logic clk_i, rst_b_i, scl_i, pclk_pin_i, pdb_n_i, remote_lock_i,
   input wire logic downstream_interrupt_in_n_i, remote_interrupt_mirror_n_o,
   input wire logic local_interrupt_n_o, pix_valid_o, pclk_edge_select_o, mode18_o,
   input wire logic [3:0] gpo_o, gpio_o, gpio_oe_o, bc_gpio_i,
   input wire ssc_pkg::ssc_freq_mode_t freq_mode_o,
   input wire ssc_pkg::ssc_i2s_t i2s_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_mirror_lock: assert property ((!remote_lock_i) [*4] |-> !remote_interrupt_mirror_n_o)
      else $error("mirror high without lock");
   a_mirror_low: assert property ((!downstream_interrupt_in_n_i) [*4] |-> !remote_interrupt_mirror_n_o)
      else $error("mirror missed remote low");
   a_mirror_high: assert property ((remote_lock_i && downstream_interrupt_in_n_i) [*5] |-> remote_interrupt_mirror_n_o)
      else $error("mirror missed remote high");
   a_local_cause: assert property ($fell(local_interrupt_n_o) |-> !remote_interrupt_mirror_n_o)
      else $error("local interrupt without remote cause");
   a_register_driven_output: assert property (!$stable(gpo_o) |-> !$past(scl_i, 2) || !$past(scl_i, 3))
      else $error("output line changed without bus write");
   a_pix_rise: assert property ($rose(pclk_pin_i) && pclk_edge_select_o && pdb_n_i |-> ##[2:4] pix_valid_o)
      else $error("no capture on rising edge");
   a_freq_hot: assert property ($past(rst_b_i) |-> $onehot(freq_mode_o))
      else $error("frequency mode not one-hot");
   a_i2s_quiet: assert property (mode18_o && $past(mode18_o) |-> i2s_o == 3'h0)
      else $error("audio passed in 18-bit mode");
   a_gpio_back: assert property (gpio_oe_o[3] && $past(gpio_oe_o[3]) |-> gpio_o[3] == $past(bc_gpio_i[3]))
      else $error("back channel gpio not driven");
endmodule
bind ssc_top ssc_chk u_chk (.*);
`default_nettype wire

/* File: dv/ssc_remote.sv */
// model of the remote deserializer: lock, interrupt status, back channel gpio
`timescale 1ns/1ns
`default_nettype none
module ssc_remote (
   input  wire logic       clk_i,
   input  wire logic       up_i,
   input  wire logic       irq_i,
   output logic            lock_o,
   output logic            local_interrupt_n_n_o,
   output logic [3:0]      bc_o
);
   logic [2:0] cnt_reg = 3'h0;
   logic [3:0] bc_reg = 4'h0;
   // lock needs seven cycles of a live link, drops at once
   always_ff @(posedge clk_i) cnt_reg <= !up_i ? 3'h0 : (&cnt_reg ? cnt_reg : cnt_reg + 3'h1);
   always_ff @(posedge clk_i) bc_reg <= bc_reg + 4'h7;
   assign lock_o = &cnt_reg;
   assign local_interrupt_n_n_o = !(lock_o && irq_i);
   assign bc_o = bc_reg;
endmodule
`default_nettype wire

/* File: dv/tb_serializer_sideband_control.sv */
// testbench of the sideband control block
`timescale 1ns/1ns
`include "ssc_consts.svh"
`default_nettype none
module tb_serializer_sideband_control;
   logic clk_i = 0, rst_b_i = 0, scl = 1, sdam = 1, frequency_select_pin = 0, alt = 0, pdb = 1, pclk = 0;
   logic up = 0, irq = 0, lock, local_interrupt_n, sdo, sdoe, mir, loc, esel, m18, pv, aav;
   logic [5:0] flt = 0;
   logic [23:0] pix = 0, pixo, a, b;
   logic [3:0] gpo = 0, bc, gio, goe, fwd, gpoo, gpooe;
   logic [7:0] d;
   logic [8:0] q;
   ssc_pkg::ssc_freq_mode_t fm;
   ssc_pkg::ssc_i2s_t i2s = 3'h5, i2so;
   int fail_count = 0, compares = 0, seed = 32'h2f5e, cyc = 0, i, n;
   wire sda = sdam & ~sdoe;
   ssc_remote u_rem (.clk_i(clk_i), .up_i(up), .irq_i(irq), .lock_o(lock), .local_interrupt_n_n_o(local_interrupt_n), .bc_o(bc));
   ssc_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
      .sda_oe_o(sdoe), .frequency_select_pin_i(frequency_select_pin), .mode_sel_alt_freq_i(alt), .pdb_n_i(pdb),
      .freq_mode_o(fm), .link_fault_i(flt), .remote_lock_i(lock), .downstream_interrupt_in_n_i(local_interrupt_n),
      .remote_interrupt_mirror_n_o(mir), .local_interrupt_n_o(loc), .pclk_pin_i(pclk),
      .pix_data_i(pix), .pix_data_o(pixo), .pix_valid_o(pv), .pclk_edge_select_o(esel),
      .mode18_o(m18), .gpio_i(~gpo), .gpio_o(gio), .gpio_oe_o(goe), .bc_gpio_i(bc), .fwd_gpio_o(fwd),
      .gpo_i(gpo), .gpo_o(gpoo), .gpo_oe_o(gpooe), .i2s_i(i2s), .i2s_o(i2so),
      .audio_active_video_o(aav));
   initial forever #5 clk_i = ~clk_i;
   task automatic w(input int k); repeat (k) @(posedge clk_i); endtask
   task automatic chk(input logic [23:0] got, exp);
      compares++;
      if (got !== exp) begin fail_count++; $display("Error %0t: got %h exp %h", $time, got, exp); end
   endtask
   task automatic wrap_up;
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // open-drain bus: the bench only ever releases or pulls sda
   task automatic xb(input logic [8:0] v);
      for (int k = 8; k >= 0; k--) begin
         sdam <= v[k]; w(5); scl <= 1; w(5); q[k] = sda; scl <= 0; w(2);
      end
   endtask
   task automatic st; sdam <= 1; w(2); scl <= 1; w(5); sdam <= 0; w(5); scl <= 0; w(2); endtask
   task automatic sp; sdam <= 0; w(2); scl <= 1; w(5); sdam <= 1; w(5); endtask
   task automatic wr(input logic [7:0] o, v);
      st; xb({`SSC_DEV_ADDR, 2'b01}); xb({o, 1'b1}); xb({v, 1'b1}); sp;
   endtask
   task automatic rd(input logic [7:0] o, output logic [7:0] v);
      st; xb({`SSC_DEV_ADDR, 2'b01}); xb({o, 1'b1});
      st; xb({`SSC_DEV_ADDR, 2'b11}); xb(9'h1FF); v = q[8:1]; sp;
   endtask
   function automatic logic [2:0] fmx(input logic f, al);
      return al ? (f ? 3'b010 : 3'b001) : 3'b100;
   endfunction
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin fail_count++; wrap_up; end
   end
   initial begin
      w(2); rst_b_i <= 1; w(4);
      for (i = 0; i < 4; i++) begin {frequency_select_pin, alt} <= i[1:0]; w(6); chk(fm, fmx(i[1], i[0])); end
      wr(8'h35, 8'h80); wr(8'h04, 8'h02); chk(fm, fmx(0, 0));
      up <= 1; w(12); rd(8'h0C, d); chk(d[0], 1'b1);
      for (i = 0; i < 6; i++) begin flt <= 6'h01 << i; rd(8'h0C, d); chk(d[0], 1'b0); end
      flt <= 0; irq <= 1; w(10); chk({loc, mir}, 2'b10);
      irq <= 0; rd(8'hC7, d); wr(8'hC6, 8'h21); irq <= 1; w(10); chk(loc, 1'b0);
      irq <= 0; rd(8'hC7, d); chk(d[5], 1'b1); w(2); chk({loc, sdo}, 2'b10);
      chk(esel, 1'b1);
      for (i = 0; i < 4; i++) begin
         if (i == 2) begin wr(8'h13, 8'h02); chk(aav, 1'b1); end
         a = $random(seed); b = $random(seed);
         pix <= a; w(2); pclk <= 1; w(6); pix <= b; w(2); pclk <= 0; w(6);
         chk(pixo, i < 2 ? a : b);
      end
      wr(8'h14, 8'h01); n = 0; repeat (200) begin w(1); n += pv; end chk(n > 0, 1'b1);
      pdb <= 0; w(4); n = 0; repeat (100) begin w(1); n += (pv !== 1'b0); end chk(n, 0);
      pdb <= 1; i2s <= 3'($random(seed)); wr(8'h14, 8'h00); w(6); chk(i2so, i2s);
      wr(8'h12, 8'h04); chk(m18, 1'b1);
      for (i = 0; i < 8; i++) begin
         n = 3 - i / 2;
         wr(n == 3 ? 8'h11 : n > 0 ? 8'h10 : 8'h0F, (i[0] ? 8'h01 : 8'h09) << (n[0] ? 0 : 4));
         w(4); chk({gpooe[n], gpoo[n]}, {1'b1, !i[0]});
      end
      wr(8'h0E, 8'h33); wr(8'h10, 8'h03); wr(8'h0F, 8'h35); gpo <= $random(seed); w(6);
      chk({gpooe[0], fwd[2:0], goe[3]}, {1'b0, ~gpo[2], gpo[1:0], 1'b1});
      up <= 0; w(12); chk(mir, 1'b0);
      wrap_up;
   end
endmodule
`default_nettype wire
